/* File: hdl/fbp_pkg.sv */
// Purpose: constants and types for the flash block protection logic
// Assumes: 100 MHz sys_clk, AXI4-Lite register access
// Notes: offsets are byte addresses of 32-bit words
package fbp_pkg;
   localparam int SYS_CLK_MHZ = 100;
   localparam int BLK_LOG2 = 11;
   localparam int NB_LOG2 = 6;
   localparam int NB = 64;
   localparam int ADDR_W = 8;
   localparam logic [7:0] CPU_RST = 8'(SYS_CLK_MHZ);
   localparam logic [15:0] PROG_US = 16'h0014;
   localparam logic [15:0] ERASE_US = 16'h0028;
   localparam logic [15:0] COMMIT_US = 16'h0028;
   localparam logic [31:0] USER_ERASED = 32'hffffffff;
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STAT = 8'h04;
   localparam logic [7:0] OFS_BADDR = 8'h08;
   localparam logic [7:0] OFS_LVL = 8'h0c;
   localparam logic [7:0] OFS_QRES = 8'h10;
   localparam logic [7:0] OFS_USEC = 8'h14;
   localparam logic [7:0] OFS_USER0 = 8'h18;
   localparam logic [7:0] OFS_USER1 = 8'h1c;
   localparam logic [7:0] OFS_ISTS = 8'h20;
   localparam logic [7:0] OFS_IEN = 8'h24;
   localparam logic [7:0] OFS_ICLR = 8'h28;
   localparam logic [7:0] OFS_IMSK = 8'h2c;
   localparam int STAT_BUSY = 0;
   localparam int STAT_FAIL = 1;
   localparam int STAT_DONE = 2;
   localparam int IRQ_VIOL = 0;
   localparam int IRQ_OPDONE = 1;
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
   typedef enum logic [1:0] {
      level_full_access = 2'b00,
      level_no_modify = 2'b01,
      level_fetch_only = 2'b10,
      level_undefined = 2'b11
   } fbp_level_t;
   typedef enum logic [1:0] {
      acc_fetch = 2'b00,
      acc_data_read = 2'b01,
      acc_erase = 2'b10,
      acc_program = 2'b11
   } fbp_acc_kind_t;
   typedef enum logic [2:0] {
      cmd_none = 3'b000,
      protection_change = 3'b001,
      protection_query = 3'b010,
      protection_commit = 3'b011,
      user_word_commit = 3'b100
   } fbp_cmd_t;
   typedef enum logic [1:0] {
      op_prot_commit = 2'b00,
      op_user_commit = 2'b01,
      op_erase = 2'b10,
      op_program = 2'b11
   } fbp_op_t;
   typedef enum logic {
      st_idle = 1'b0,
      st_timed = 1'b1
   } fbp_state_t;
   typedef struct packed {
      logic valid;
      fbp_acc_kind_t kind;
      logic [31:0] addr;
   } fbp_acc_req_t;
   typedef struct packed {
      logic [NB*2-1:0] lvl;
      logic [NB*2-1:0] nv_lvl;
      logic [31:0] usr0;
      logic [31:0] usr1;
      logic [31:0] nv_usr0;
      logic [31:0] nv_usr1;
      logic [7:0] cpu;
      fbp_state_t st;
      fbp_op_t op;
      logic [7:0] div;
      logic [15:0] ucnt;
      logic [31:0] baddr;
      fbp_level_t arg;
      fbp_level_t qres;
      logic fail;
      logic done;
      logic [1:0] ists;
      logic [1:0] ien;
      logic irq;
      logic aw_got;
      logic w_got;
      logic [ADDR_W-1:0] waddr;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic acc_ok;
      logic acc_fault;
      logic err_s1;
      logic err_s2;
   } fbp_regs_t;
endpackage

/* File: hdl/fbp_top.sv */
// Purpose: flash block protection, user words and op timing
// Assumes: AXI4-Lite master, one access at a time per direction
// Notes: permanent store modelled by nv_* fields, cleared only by por_rst
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
module fbp_top (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic [fbp_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fbp_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fbp_pkg::fbp_acc_req_t acc_req,
   output logic acc_ok,
   output logic acc_fault,
   input wire logic nv_error,
   output logic busy,
   output logic irq
);
   import fbp_pkg::*;

   fbp_regs_t s_reg;
   fbp_regs_t s_next;

   function automatic logic [NB_LOG2-1:0] blk_idx(input logic [31:0] a);
      return a[BLK_LOG2+NB_LOG2-1:BLK_LOG2];
   endfunction

   function automatic logic in_range(input logic [31:0] a);
      return a[31:BLK_LOG2+NB_LOG2] == '0;
   endfunction

   function automatic fbp_level_t lvl_get(input logic [NB*2-1:0] t,
                                          input logic [NB_LOG2-1:0] i);
      return fbp_level_t'(t[{i, 1'b0} +: 2]);
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] o,
                                         input logic [31:0] d,
                                         input logic [3:0] b);
      logic [31:0] r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (b[k]) begin
            r[k*8 +: 8] = d[k*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic [15:0] op_time(input fbp_op_t o);
      logic [15:0] t;
      t = COMMIT_US;
      if (o == op_erase) begin
         t = ERASE_US;
      end else if (o == op_program) begin
         t = PROG_US;
      end
      return t;
   endfunction

   always_comb begin
      fbp_regs_t n;
      logic [31:0] wv;
      logic [31:0] rv;
      logic [1:0] resp;
      logic [1:0] iset;
      logic [1:0] iclr;
      logic tick;
      logic prot_ok;
      logic modify;
      logic ok;
      fbp_level_t cur;
      fbp_level_t lv;
      logic [NB_LOG2-1:0] ix;
      n = s_reg;
      wv = '0;
      rv = '0;
      resp = RESP_OKAY;
      iset = '0;
      iclr = '0;
      tick = 1'b0;
      prot_ok = 1'b0;
      modify = 1'b0;
      ok = 1'b0;
      cur = level_full_access;
      lv = level_full_access;
      ix = '0;
      n.acc_ok = 1'b0;
      n.acc_fault = 1'b0;
      // synchroniser for the store's error line
      n.err_s1 = nv_error;
      n.err_s2 = s_reg.err_s1;

      // timed store and modify operations
      if (s_reg.st == st_timed) begin
         tick = (s_reg.div + 8'h01) >= s_reg.cpu;
         n.div = tick ? 8'h00 : s_reg.div + 8'h01;
         if (tick) begin
            n.ucnt = s_reg.ucnt + 16'h0001;
            if (s_reg.ucnt >= op_time(s_reg.op) - 16'h0001) begin
               n.st = st_idle;
               n.ucnt = '0;
               if (s_reg.op == op_erase || s_reg.op == op_program) begin
                  iset[IRQ_OPDONE] = 1'b1;
               end else begin
                  n.done = 1'b1;
                  n.fail = s_reg.err_s2;
                  if (!s_reg.err_s2) begin
                     if (s_reg.op == op_prot_commit) begin
                        n.nv_lvl = s_reg.lvl;
                     end else begin
                        n.nv_usr0 = s_reg.usr0;
                        n.nv_usr1 = s_reg.usr1;
                     end
                  end
               end
            end
         end
      end

      // write channel capture, address and data in either order
      if (s_axi_awvalid && s_reg.awready) begin
         n.aw_got = 1'b1;
         n.waddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_reg.wready) begin
         n.w_got = 1'b1;
         n.wdata = s_axi_wdata;
         n.wstrb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         n.bvalid = 1'b0;
      end
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid) begin
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.bvalid = 1'b1;
         wv = merge(32'h00000000, s_reg.wdata, s_reg.wstrb);
         if (s_reg.waddr == OFS_CTRL) begin
            // commands are refused while a store is running
            if (s_reg.st != st_idle) begin
               resp = RESP_SLVERR;
            end else if (fbp_cmd_t'(wv[2:0]) == protection_change) begin
               ix = blk_idx(s_reg.baddr);
               cur = lvl_get(s_reg.lvl, ix);
               n.done = 1'b1;
               n.fail = 1'b1;
               if (in_range(s_reg.baddr) && s_reg.arg != level_undefined) begin
                  // strictness grows with the code value
                  if (s_reg.arg >= cur) begin
                     n.fail = 1'b0;
                     n.lvl[{ix, 1'b0} +: 2] = s_reg.arg;
                  end
               end
            end else if (fbp_cmd_t'(wv[2:0]) == protection_query) begin
               n.done = 1'b1;
               n.fail = !in_range(s_reg.baddr);
               n.qres = lvl_get(s_reg.lvl, blk_idx(s_reg.baddr));
            end else if (fbp_cmd_t'(wv[2:0]) == protection_commit) begin
               n.st = st_timed;
               n.op = op_prot_commit;
               n.div = '0;
               n.ucnt = '0;
               n.done = 1'b0;
               n.fail = 1'b0;
            end else if (fbp_cmd_t'(wv[2:0]) == user_word_commit) begin
               n.st = st_timed;
               n.op = op_user_commit;
               n.div = '0;
               n.ucnt = '0;
               n.done = 1'b0;
               n.fail = 1'b0;
            end
         end else if (s_reg.waddr == OFS_BADDR) begin
            n.baddr = merge(s_reg.baddr, s_reg.wdata, s_reg.wstrb);
         end else if (s_reg.waddr == OFS_LVL) begin
            n.arg = fbp_level_t'(wv[1:0]);
            if (!s_reg.wstrb[0]) begin
               n.arg = s_reg.arg;
            end
         end else if (s_reg.waddr == OFS_USEC) begin
            if (s_reg.wstrb[0]) begin
               n.cpu = s_reg.wdata[7:0];
            end
         end else if (s_reg.waddr == OFS_USER0) begin
            if (s_reg.st != st_idle) begin
               resp = RESP_SLVERR;
            end else begin
               n.usr0 = merge(s_reg.usr0, s_reg.wdata, s_reg.wstrb);
            end
         end else if (s_reg.waddr == OFS_USER1) begin
            if (s_reg.st != st_idle) begin
               resp = RESP_SLVERR;
            end else begin
               n.usr1 = merge(s_reg.usr1, s_reg.wdata, s_reg.wstrb);
            end
         end else if (s_reg.waddr == OFS_IEN) begin
            if (s_reg.wstrb[0]) begin
               n.ien = s_reg.wdata[1:0];
            end
         end else if (s_reg.waddr == OFS_ICLR) begin
            iclr = wv[1:0];
         end else begin
            resp = RESP_SLVERR;
         end
         n.bresp = resp;
      end
      n.awready = !n.aw_got && !n.bvalid;
      n.wready = !n.w_got && !n.bvalid;

      // read channel
      if (s_axi_rvalid && s_axi_rready) begin
         n.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_reg.arready) begin
         resp = RESP_OKAY;
         if (s_axi_araddr == OFS_STAT) begin
            rv[STAT_BUSY] = s_reg.st != st_idle;
            rv[STAT_FAIL] = s_reg.fail;
            rv[STAT_DONE] = s_reg.done;
         end else if (s_axi_araddr == OFS_BADDR) begin
            rv = s_reg.baddr;
         end else if (s_axi_araddr == OFS_LVL) begin
            rv[1:0] = s_reg.arg;
         end else if (s_axi_araddr == OFS_QRES) begin
            rv[1:0] = s_reg.qres;
         end else if (s_axi_araddr == OFS_USEC) begin
            rv[7:0] = s_reg.cpu;
         end else if (s_axi_araddr == OFS_USER0) begin
            rv = s_reg.usr0;
         end else if (s_axi_araddr == OFS_USER1) begin
            rv = s_reg.usr1;
         end else if (s_axi_araddr == OFS_ISTS) begin
            rv[1:0] = s_reg.ists;
         end else if (s_axi_araddr == OFS_IEN) begin
            rv[1:0] = s_reg.ien;
         end else if (s_axi_araddr == OFS_IMSK) begin
            rv[1:0] = s_reg.ists & s_reg.ien;
         end else if (s_axi_araddr == OFS_CTRL || s_axi_araddr == OFS_ICLR) begin
            rv = '0;
         end else begin
            resp = RESP_SLVERR;
         end
         n.rvalid = 1'b1;
         n.rdata = rv;
         n.rresp = resp;
      end
      n.arready = !n.rvalid;

      // access check; the cycle count plays no part here
      if (acc_req.valid) begin
         lv = lvl_get(s_reg.lvl, blk_idx(acc_req.addr));
         modify = acc_req.kind == acc_erase || acc_req.kind == acc_program;
         if (!in_range(acc_req.addr)) begin
            prot_ok = 1'b0;
         end else if (acc_req.kind == acc_fetch) begin
            prot_ok = 1'b1;
         end else if (acc_req.kind == acc_data_read) begin
            prot_ok = lv != level_fetch_only;
         end else begin
            prot_ok = lv == level_full_access;
         end
         // a controller busy in the next cycle refuses modify ops with acc_fault but sets no IRQ_VIOL for them
         ok = prot_ok && !(modify && n.st != st_idle);
         n.acc_ok = ok;
         n.acc_fault = !ok;
         iset[IRQ_VIOL] = !prot_ok;
         if (ok && modify) begin
            n.st = st_timed;
            n.op = acc_req.kind == acc_erase ? op_erase : op_program;
            n.div = '0;
            n.ucnt = '0;
         end
      end

      // a set in the clearing cycle wins
      n.ists = (s_reg.ists & ~iclr) | iset;
      n.irq = |(n.ists & n.ien);

      if (rst || por_rst) begin
         if (por_rst) begin
            n.nv_lvl = '0;
            n.nv_usr0 = USER_ERASED;
            n.nv_usr1 = USER_ERASED;
         end
         n.lvl = n.nv_lvl;
         n.usr0 = n.nv_usr0;
         n.usr1 = n.nv_usr1;
         n.cpu = CPU_RST;
         n.st = st_idle;
         n.op = op_prot_commit;
         n.div = '0;
         n.ucnt = '0;
         n.baddr = '0;
         n.arg = level_full_access;
         n.qres = level_full_access;
         n.fail = 1'b0;
         n.done = 1'b0;
         n.ists = '0;
         n.ien = '0;
         n.irq = 1'b0;
         n.aw_got = 1'b0;
         n.w_got = 1'b0;
         n.waddr = '0;
         n.wdata = '0;
         n.wstrb = '0;
         n.awready = 1'b0;
         n.wready = 1'b0;
         n.bvalid = 1'b0;
         n.bresp = RESP_OKAY;
         n.arready = 1'b0;
         n.rvalid = 1'b0;
         n.rdata = '0;
         n.rresp = RESP_OKAY;
         n.acc_ok = 1'b0;
         n.acc_fault = 1'b0;
         n.err_s1 = 1'b0;
         n.err_s2 = 1'b0;
      end
      s_next = n;
   end

   // store lives in the same struct; only por_rst clears it
   always_ff @(posedge sys_clk) begin
      s_reg <= s_next;
   end

   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign s_axi_rvalid = s_reg.rvalid;
   assign acc_ok = s_reg.acc_ok;
   assign acc_fault = s_reg.acc_fault;
   assign busy = s_reg.st == st_timed;
   assign irq = s_reg.irq;
endmodule

/* File: dv/fbp_props.sv */
// Purpose: port-level checks for the flash block protection logic
// Assumes: one clock, both resets synchronous and active high
// Notes: busy run bound covers the largest cycles-per-us value
`timescale 1ns/1ps
module fbp_props (
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic por_rst,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fbp_pkg::fbp_acc_req_t acc_req,
   input wire logic acc_ok,
   input wire logic acc_fault,
   input wire logic busy,
   input wire logic irq
);
   import fbp_pkg::*;
   logic [15:0] bcnt_reg;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst || por_rst);
   // longest timed run is 40 us at 255 cycles per us
   always_ff @(posedge sys_clk) begin
      if (rst || por_rst || !busy) begin
         bcnt_reg <= 16'h0000;
      end else begin
         bcnt_reg <= bcnt_reg + 16'h0001;
      end
   end
   a_one_answer: assert property (acc_req.valid |=> acc_ok ^ acc_fault)
      else $error("access not answered exactly once");
   a_no_stray: assert property (!acc_req.valid |=> !(acc_ok || acc_fault))
      else $error("access answer without request");
   a_range_fault: assert property (acc_req.valid && acc_req.addr[31:17] != 15'h0000
      |=> acc_fault) else $error("out of range access allowed");
   a_busy_refuse: assert property (busy && acc_req.valid && acc_req.kind[1] |=> acc_fault)
      else $error("modify access granted while busy");
   a_busy_bound: assert property (busy |-> bcnt_reg < 16'h27d8)
      else $error("timed operation overran");
   a_aw_wait: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready [*2])
      else $error("write address ready too early");
   a_write_resp: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
      else $error("write response not retired");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   a_read_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read not retired");
   cover property (acc_req.valid ##1 acc_fault);
   cover property ($fell(busy));
   cover property ($rose(irq));
endmodule

bind fbp_top fbp_props fbp_props_i (.sys_clk(sys_clk), .rst(rst), .por_rst(por_rst),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
   .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .acc_req(acc_req),
   .acc_ok(acc_ok), .acc_fault(acc_fault), .busy(busy), .irq(irq));

/* File: dv/fbp_cpu_model.sv */
// Purpose: processor and debugger side issuing flash accesses
// Assumes: request valid one cycle, answer sampled the cycle after
// Notes: address inverted once released so a stale value never matches
`timescale 1ns/1ps
module fbp_cpu_model (
   input wire logic sys_clk,
   output fbp_pkg::fbp_acc_req_t acc_req,
   input wire logic acc_ok,
   input wire logic acc_fault,
   output logic nv_error
);
   import fbp_pkg::*;
   initial begin
      acc_req = '0;
      nv_error = 1'b0;
   end
   task automatic issue(input fbp_acc_kind_t k, input logic [31:0] a, output logic ok,
      output logic flt);
      @(posedge sys_clk);
      acc_req <= '{valid: 1'b1, kind: k, addr: a};
      @(posedge sys_clk);
      acc_req <= '{valid: 1'b0, kind: k, addr: ~a};
      @(posedge sys_clk);
      ok = acc_ok;
      flt = acc_fault;
   endtask
   task automatic store_fault(input logic v);
      @(posedge sys_clk);
      nv_error <= v;
   endtask
endmodule

/* File: dv/tb_top.sv */
// Purpose: self-checking bench for flash block protection
// Assumes: cycles per us lowered so timed operations stay short
// Notes: every scenario drives the block and judges its answers itself
`timescale 1ns/1ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module tb_top;
   import fbp_pkg::*;
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic por_rst = 1'b1;
   logic [7:0] awa = 8'h00, ara = 8'h00;
   logic awv = 1'b0, wv = 1'b0, arv = 1'b0, br = 1'b0, rr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic awr, wrd, bv, arr, rv, ok, flt, busy, irq, nve, aok, afl;
   logic [1:0] bresp, rresp, resp;
   logic [31:0] rd, q;
   fbp_acc_req_t acc;
   int err_total = 0;
   int n_checks = 0;
   int n;
   always #5 sys_clk = ~sys_clk;
   fbp_top fbp_top_i (.sys_clk(sys_clk), .rst(rst), .por_rst(por_rst),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .acc_req(acc), .acc_ok(aok), .acc_fault(afl), .nv_error(nve),
      .busy(busy), .irq(irq));
   fbp_cpu_model fbp_cpu_model_i (.sys_clk(sys_clk), .acc_req(acc), .acc_ok(aok),
      .acc_fault(afl), .nv_error(nve));
   task automatic summarize();
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic hang();
      `CHK(1'b1, 1'b0)
      summarize();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      int k;
      k = 0;
      @(posedge sys_clk);
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      br <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
         if (awv && awr) awv <= 1'b0;
         if (wv && wrd) wv <= 1'b0;
         if (k > 300) hang();
      end while (!bv);
      r = bresp;
      br <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e);
      int k;
      k = 0;
      @(posedge sys_clk);
      ara <= a;
      arv <= 1'b1;
      rr <= 1'b1;
      do begin
         @(posedge sys_clk);
         k++;
         if (arv && arr) arv <= 1'b0;
         if (k > 300) hang();
      end while (!rv);
      q = rd;
      resp = rresp;
      rr <= 1'b0;
      `CHK(q, e)
   endtask
   task automatic acc_chk(input fbp_acc_kind_t k, input logic [31:0] a, input logic e_ok);
      fbp_cpu_model_i.issue(k, a, ok, flt);
      `CHK({ok, flt}, {e_ok, !e_ok})
   endtask
   task automatic chg(input logic [31:0] ba, input logic [1:0] l, input logic fail);
      wr(OFS_BADDR, ba, resp);
      wr(OFS_LVL, {30'h0, l}, resp);
      wr(OFS_CTRL, 32'h1, resp);
      rchk(OFS_STAT, {29'h0, 1'b1, fail, 1'b0});
   endtask
   task automatic qry(input logic [31:0] ba, input logic [1:0] l);
      wr(OFS_BADDR, ba, resp);
      wr(OFS_CTRL, 32'h2, resp);
      rchk(OFS_QRES, {30'h0, l});
   endtask
   task automatic idle_wait();
      n = 0;
      while (busy === 1'b1) begin
         @(posedge sys_clk);
         n++;
         if (n > 20000) hang();
      end
   endtask
   task automatic do_reset(input logic por);
      @(posedge sys_clk);
      rst <= 1'b1;
      por_rst <= por;
      repeat (5) @(posedge sys_clk);
      rst <= 1'b0;
      por_rst <= 1'b0;
   endtask
   // refused store write and modify access ride along while the commit runs
   task automatic commit(input logic [31:0] cmd, input logic fail);
      wr(OFS_CTRL, cmd, resp);
      `CHK(busy, 1'b1)
      acc_chk(acc_erase, 32'h0, 1'b0);
      wr(OFS_USER1, 32'h0, resp);
      `CHK(resp, RESP_SLVERR)
      idle_wait();
      `CHK(n > 20 && n < 40, 1'b1)
      rchk(OFS_STAT, {29'h0, 1'b1, fail, 1'b0});
   endtask
   task automatic t_start();
      rchk(OFS_USEC, 32'h64);
      rchk(OFS_USER0, USER_ERASED);
      rchk(OFS_USER1, USER_ERASED);
      qry(32'hf800, 2'h0);
      rchk(8'h30, 32'h0);
      `CHK(resp, RESP_SLVERR)
      wr(8'h30, 32'h0, resp);
      `CHK(resp, RESP_SLVERR)
      $display("test start done");
   endtask
   task automatic t_levels();
      wr(OFS_USEC, 32'h1, resp);
      chg(32'h800, 2'h1, 1'b0);
      chg(32'h800, 2'h1, 1'b0);
      chg(32'h800, 2'h0, 1'b1);
      chg(32'h800, 2'h2, 1'b0);
      chg(32'h1000, 2'h2, 1'b0);
      chg(32'h1000, 2'h1, 1'b1);
      chg(32'h1000, 2'h0, 1'b1);
      chg(32'h1800, 2'h3, 1'b1);
      chg(32'h20000, 2'h1, 1'b1);
      chg(32'h2000, 2'h1, 1'b0);
      qry(32'h800, 2'h2);
      qry(32'h1800, 2'h0);
      acc_chk(acc_data_read, 32'h1004, 1'b0);
      acc_chk(acc_fetch, 32'h1004, 1'b1);
      acc_chk(acc_data_read, 32'h2010, 1'b1);
      acc_chk(acc_fetch, 32'h2010, 1'b1);
      acc_chk(acc_erase, 32'h2000, 1'b0);
      acc_chk(acc_program, 32'h2010, 1'b0);
      acc_chk(acc_fetch, 32'h20000, 1'b0);
      acc_chk(acc_program, 32'h0, 1'b1);
      idle_wait();
      `CHK(n >= 19 && n <= 21, 1'b1)
      wr(OFS_USEC, 32'hff, resp);
      rchk(OFS_USEC, 32'hff);
      acc_chk(acc_data_read, 32'h0, 1'b1);
      wr(OFS_USEC, 32'h2, resp);
      acc_chk(acc_erase, 32'h7fc, 1'b1);
      idle_wait();
      `CHK(n >= 79 && n <= 81, 1'b1)
      wr(OFS_USEC, 32'h1, resp);
      $display("test levels done");
   endtask
   task automatic t_irq();
      rchk(OFS_ISTS, 32'h3);
      `CHK(irq, 1'b0)
      wr(OFS_IEN, 32'h1, resp);
      rchk(OFS_IMSK, 32'h1);
      `CHK(irq, 1'b1)
      wr(OFS_ICLR, 32'h1, resp);
      rchk(OFS_ISTS, 32'h2);
      `CHK(irq, 1'b0)
      wr(OFS_IEN, 32'h3, resp);
      rchk(OFS_IEN, 32'h3);
      rchk(OFS_IMSK, 32'h2);
      `CHK(irq, 1'b1)
      wr(OFS_ICLR, 32'h3, resp);
      rchk(OFS_ISTS, 32'h0);
      acc_chk(acc_data_read, 32'h1000, 1'b0);
      rchk(OFS_ISTS, 32'h1);
      `CHK(irq, 1'b1)
      wr(OFS_ICLR, 32'h1, resp);
      $display("test irq done");
   endtask
   task automatic t_commit();
      fbp_cpu_model_i.store_fault(1'b1);
      commit(32'h3, 1'b1);
      fbp_cpu_model_i.store_fault(1'b0);
      commit(32'h3, 1'b0);
      wr(OFS_USER0, 32'ha5a50f0f, resp);
      `CHK(resp, RESP_OKAY)
      wr(OFS_USER1, 32'h01234567, resp);
      rchk(OFS_USER0, 32'ha5a50f0f);
      commit(32'h4, 1'b0);
      rchk(OFS_USER1, 32'h01234567);
      rchk(OFS_ISTS, 32'h0);
      chg(32'h2800, 2'h2, 1'b0);
      do_reset(1'b0);
      qry(32'h2000, 2'h1);
      qry(32'h1000, 2'h2);
      qry(32'h2800, 2'h0);
      rchk(OFS_USER0, 32'ha5a50f0f);
      rchk(OFS_USER1, 32'h01234567);
      rchk(OFS_USEC, 32'h64);
      $display("test commit done");
   endtask
   initial begin
      do_reset(1'b1);
      t_start();
      t_levels();
      t_irq();
      t_commit();
      summarize();
   end
endmodule
